// File: rtl/spi_flash_protect_consts.vh
// Constants shared by the serial nonvolatile memory front end
`ifndef SPI_FLASH_PROTECT_CONSTS_VH
`define SPI_FLASH_PROTECT_CONSTS_VH
// Instruction codes
`define OP_STATUS_PROG  8'h01
`define OP_PROGRAM      8'h02
`define OP_READ         8'h03
`define OP_DISARM       8'h04
`define OP_STATUS_READ  8'h05
`define OP_ARM          8'h06
// Array and sector geometry
`define ARRAY_AW        10
`define PAGE_AW         4
`define PAGE_BYTES      5'h10
`define READ_ADDR_LSB   0
`define PROG_ADDR_W     9
// Status byte layout and reset value
`define LOCK_SEL_MSB    2
`define LOCK_SEL_LSB    0
`define STATUS_RESET    3'h0
// Lock region encodings
`define LOCK_NONE       3'h0
`define LOCK_Q1         3'h1
`define LOCK_Q2         3'h2
`define LOCK_Q3         3'h3
`define LOCK_Q4         3'h4
`define LOCK_H1         3'h5
`define LOCK_S0         3'h6
`define LOCK_SN         3'h7
// Read-ahead buffer shape
`define RFIFO_WIDTH     8
`define RFIFO_DEPTH     8
`define RFIFO_PTR_W     3
// Self-timed write cycle: time in microseconds, clock rate in MHz
`define PROG_TIME_US    5000
`define MCLK_MHZ        200
`define WAIT_CNT_W      20
`endif

// File: rtl/nv_store_ram.v
// Simple dual-port storage with registered read data
module nv_store_ram #(
	parameter AW = 10,
	parameter DW = 8
) (
	input  wire          clk,
	input  wire          wrEn,
	input  wire [AW-1:0] wrAddr,
	input  wire [DW-1:0] wrData,
	input  wire          rdEn,
	input  wire [AW-1:0] rdAddr,
	output reg  [DW-1:0] rdData
);
	// Storage cells, contents undefined until written
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Write port and registered read port
	always @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		if (rdEn) begin
			rdData <= mem[rdAddr];
		end
	end
endmodule

// File: rtl/read_fifo.v
// Small synchronous FIFO with valid/ready on both sides and a flush
module read_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter PW    = 3
) (
	input  wire             clk,
	input  wire             srst,
	input  wire             flush,
	input  wire             inValid,
	output wire             inReady,
	input  wire [WIDTH-1:0] inData,
	output wire             outValid,
	input  wire             outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] store [0:DEPTH-1]; // Entry storage
	reg [PW-1:0]    wrPtr_reg;         // Next slot to fill
	reg [PW-1:0]    rdPtr_reg;         // Oldest slot
	reg [PW:0]      count_reg;         // Entries held
	wire            doPush;
	wire            doPop;

	assign inReady  = (count_reg != DEPTH[PW:0]);
	assign outValid = (count_reg != {(PW+1){1'b0}});
	assign outData  = store[rdPtr_reg];
	assign doPush   = inValid & inReady;
	assign doPop    = outValid & outReady;

	// Pointer and count bookkeeping; flush empties in one cycle
	always @(posedge clk) begin
		if (srst | flush) begin
			wrPtr_reg <= {PW{1'b0}};
			rdPtr_reg <= {PW{1'b0}};
			count_reg <= {(PW+1){1'b0}};
		end else begin
			if (doPush) begin
				store[wrPtr_reg] <= inData;
				wrPtr_reg        <= wrPtr_reg + 1'b1;
			end
			if (doPop) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end
			if (doPush & ~doPop) begin
				count_reg <= count_reg + 1'b1;
			end else if (doPop & ~doPush) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// File: rtl/spi_flash_protect_protocol.v
// Serial command front end of a 1024-byte protected nonvolatile memory
`include "spi_flash_protect_consts.vh"
module spi_flash_protect_protocol #(
	parameter PROG_CYCLES = `PROG_TIME_US * `MCLK_MHZ
) (
	input  wire mclk,
	input  wire srst,
	input  wire csN,
	input  wire sck,
	input  wire si,
	input  wire writeGuardN,
	output reg  so,
	output reg  soOe
);
	// Command phases, one-hot
	localparam [7:0] S_OP    = 8'h01; // Waiting for opcode
	localparam [7:0] S_ADDR  = 8'h02; // Collecting address bytes
	localparam [7:0] S_READ  = 8'h04; // Streaming array data
	localparam [7:0] S_STAT  = 8'h08; // Streaming status bits
	localparam [7:0] S_PDATA = 8'h10; // Collecting program data
	localparam [7:0] S_SDATA = 8'h20; // Collecting lock byte
	localparam [7:0] S_CMD   = 8'h40; // Single-byte command held
	localparam [7:0] S_IGN   = 8'h80; // Rest of frame ignored
	// Write engine states, one-hot
	localparam [2:0] W_IDLE  = 3'h1;
	localparam [2:0] W_WAIT  = 3'h2;
	localparam [2:0] W_COPY  = 3'h4;
	// Cycle count kept as an integer, then cut to the counter's width
	localparam integer WAIT_LAST_I = PROG_CYCLES - 1;
	localparam [`WAIT_CNT_W-1:0] WAIT_LAST = WAIT_LAST_I[`WAIT_CNT_W-1:0];

	// Pin synchronisers; first stages feed only second stages
	reg        csS1_reg, csS2_reg, csS3_reg;
	reg        sckS1_reg, sckS2_reg, sckS3_reg;
	reg        siS1_reg, siS2_reg;
	reg        wgS1_reg, wgS2_reg, wgS3_reg;
	// Protocol state
	reg        seenFall_reg;       // A select fall has been seen
	reg [7:0]  state_reg;          // Command phase
	reg [2:0]  bitCnt_reg;         // Bit within current byte
	reg [6:0]  shift_reg;          // Input shifter
	reg [7:0]  opcode_reg;         // Latched instruction
	reg [4:0]  byteCnt_reg;        // Bytes after opcode
	reg [7:0]  addrHi_reg;         // Upper address byte
	reg [15:0] addr_reg;           // Full address from host
	reg        abort_reg;          // Guard fell during entry
	reg        armLatch_reg;       // Program enable latch
	reg [2:0]  lockSel_reg;        // Stored lock select
	reg [2:0]  pendLock_reg;       // Lock byte awaiting write
	// Read path
	reg [`ARRAY_AW-1:0] rdAddr_reg; // Next array address to fetch
	reg        rdPend_reg;          // Array read in flight
	reg        streaming_reg;       // Prefetch enabled
	reg [6:0]  tx_reg;              // Output shifter
	reg [2:0]  txCnt_reg;           // Bits left in output byte
	reg [2:0]  statPtr_reg;         // Status bit pointer
	// Write engine
	reg [2:0]  wState_reg;
	reg        wKindPage_reg;       // 1: sector, 0: status byte
	reg [`WAIT_CNT_W-1:0] waitCnt_reg;
	reg [4:0]  copyCnt_reg;
	reg [`ARRAY_AW-1:0] base_reg;   // Sector base in array

	wire csActive = ~csS2_reg;
	wire csFall   = csS3_reg & ~csS2_reg;
	wire csRise   = ~csS3_reg & csS2_reg;
	wire sckRise  = sckS2_reg & ~sckS3_reg;
	wire sckFall  = ~sckS2_reg & sckS3_reg;
	wire wgFall   = wgS3_reg & ~wgS2_reg;
	wire busy     = (wState_reg != W_IDLE);
	wire bitEdge  = sckRise & csActive & seenFall_reg;
	wire byteDone = bitEdge & (bitCnt_reg == 3'h7);
	wire [7:0] byteNew = {shift_reg, siS2_reg};
	wire outEdge  = sckFall & csActive & seenFall_reg;
	wire [7:0] statusByte = {5'h00, lockSel_reg}; // Status byte as read back

	// Fifo and memory hookups
	wire        fifoInReady;
	wire        fifoOutValid;
	wire [7:0]  fifoOutData;
	wire [7:0]  arrayRdData;
	wire [7:0]  pageRdData;
	wire        fifoPop = outEdge & (state_reg == S_READ) & (txCnt_reg == 3'h0);
	wire        rdIssue = streaming_reg & fifoInReady & ~rdPend_reg;
	wire        pageWr  = byteDone & (state_reg == S_PDATA);
	wire        copyWr  = (wState_reg == W_COPY) & (copyCnt_reg != 5'h0);
	wire [`ARRAY_AW-1:0] copyAddr = base_reg + {6'h00, copyCnt_reg[3:0] - 4'h1};
	wire [`ARRAY_AW-1:0] progBase =
		{1'b0, addr_reg[`PROG_ADDR_W-1:`PAGE_AW], 4'h0};

	// Region test for one address under a lock setting
	function locked;
		input [2:0] sel;
		input [`ARRAY_AW-1:0] a;
		begin
			case (sel)
				`LOCK_Q1: locked = (a[9:8] == 2'h0);
				`LOCK_Q2: locked = (a[9:8] == 2'h1);
				`LOCK_Q3: locked = (a[9:8] == 2'h2);
				`LOCK_Q4: locked = (a[9:8] == 2'h3);
				`LOCK_H1: locked = ~a[9];
				`LOCK_S0: locked = (a[9:4] == 6'h00);
				`LOCK_SN: locked = (a[9:4] == 6'h3f);
				default:  locked = 1'b0;
			endcase
		end
	endfunction

	// Sector program needs exact count, armed latch, guard, no lock
	wire progOk = (opcode_reg == `OP_PROGRAM) & (state_reg == S_PDATA)
		& (byteCnt_reg == `PAGE_BYTES) & (bitCnt_reg == 3'h0)
		& armLatch_reg & wgS2_reg & ~abort_reg
		& ~locked(lockSel_reg, progBase);
	// Status program needs whole lock byte, latch and guard
	wire statOk = (opcode_reg == `OP_STATUS_PROG) & (state_reg == S_SDATA)
		& (byteCnt_reg != 5'h0) & (bitCnt_reg == 3'h0)
		& armLatch_reg & wgS2_reg & ~abort_reg;
	// A one-byte command counts only with exactly eight bits
	wire cmdOk = (state_reg == S_CMD) & (bitCnt_reg == 3'h0);

	// Double-flop every pin; select chain resets low so no false fall
	always @(posedge mclk) begin
		if (srst) begin
			csS1_reg  <= 1'b0;
			csS2_reg  <= 1'b0;
			csS3_reg  <= 1'b0;
			sckS1_reg <= 1'b0;
			sckS2_reg <= 1'b0;
			sckS3_reg <= 1'b0;
			siS1_reg  <= 1'b0;
			siS2_reg  <= 1'b0;
			wgS1_reg  <= 1'b0;
			wgS2_reg  <= 1'b0;
			wgS3_reg  <= 1'b0;
		end else begin
			csS1_reg  <= csN;
			csS2_reg  <= csS1_reg;
			csS3_reg  <= csS2_reg;
			sckS1_reg <= sck;
			sckS2_reg <= sckS1_reg;
			sckS3_reg <= sckS2_reg;
			siS1_reg  <= si;
			siS2_reg  <= siS1_reg;
			wgS1_reg  <= writeGuardN;
			wgS2_reg  <= wgS1_reg;
			wgS3_reg  <= wgS2_reg;
		end
	end

	// Command decoder; within a frame only real clock edges and a guard fall move it, so a parked clock
	// simply holds every field except abort_reg where it was
	always @(posedge mclk) begin
		if (srst) begin
			seenFall_reg <= 1'b0;
			state_reg    <= S_OP;
			bitCnt_reg   <= 3'h0;
			shift_reg    <= 7'h00;
			opcode_reg   <= 8'h00;
			byteCnt_reg  <= 5'h00;
			addrHi_reg   <= 8'h00;
			addr_reg     <= 16'h0000;
			abort_reg    <= 1'b0;
			pendLock_reg <= 3'h0;
		end else if (csFall) begin
			seenFall_reg <= 1'b1;
			state_reg    <= S_OP;
			bitCnt_reg   <= 3'h0;
			byteCnt_reg  <= 5'h00;
			abort_reg    <= 1'b0;
		end else if (~csActive) begin
			state_reg <= S_OP;
		end else if (bitEdge) begin
			shift_reg  <= byteNew[6:0];
			bitCnt_reg <= bitCnt_reg + 3'h1;
			if (byteDone) begin
				case (state_reg)
					S_OP: begin
						opcode_reg  <= byteNew;
						byteCnt_reg <= 5'h00;
						if (busy && byteNew != `OP_STATUS_READ) begin
							state_reg <= S_IGN;
						end else begin
							case (byteNew)
								`OP_READ:        state_reg <= S_ADDR;
								`OP_PROGRAM:     state_reg <= S_ADDR;
								`OP_STATUS_READ: state_reg <= S_STAT;
								`OP_STATUS_PROG: state_reg <= S_SDATA;
								`OP_ARM:         state_reg <= S_CMD;
								`OP_DISARM:      state_reg <= S_CMD;
								default:         state_reg <= S_IGN;
							endcase
						end
					end
					S_ADDR: begin
						addrHi_reg  <= byteNew;
						byteCnt_reg <= byteCnt_reg + 5'h01;
						if (byteCnt_reg[0]) begin
							addr_reg    <= {addrHi_reg, byteNew};
							byteCnt_reg <= 5'h00;
							if (opcode_reg == `OP_READ) begin
								state_reg <= S_READ;
							end else begin
								state_reg <= S_PDATA;
							end
						end
					end
					S_PDATA: begin
						// Overrun counts on and holds at 31 so the exact-count test fails
						if (byteCnt_reg != 5'h1f) begin
							byteCnt_reg <= byteCnt_reg + 5'h01;
						end
					end
					S_SDATA: begin
						pendLock_reg <= byteNew[`LOCK_SEL_MSB:`LOCK_SEL_LSB];
						byteCnt_reg  <= 5'h01;
					end
					S_CMD: begin
						state_reg <= S_IGN;
					end
					default: begin
						state_reg <= state_reg;
					end
				endcase
			end
		end
		// Guard falling mid-entry spoils the pending write
		if (~srst && csActive && wgFall) begin
			abort_reg <= 1'b1;
		end
	end

	// Latch, lock byte and write engine; guard changes no longer matter
	// once the engine has left idle
	always @(posedge mclk) begin
		if (srst) begin
			armLatch_reg  <= 1'b0;
			lockSel_reg   <= `STATUS_RESET;
			wState_reg    <= W_IDLE;
			wKindPage_reg <= 1'b0;
			waitCnt_reg   <= {`WAIT_CNT_W{1'b0}};
			copyCnt_reg   <= 5'h00;
			base_reg      <= {`ARRAY_AW{1'b0}};
		end else begin
			case (wState_reg)
				W_IDLE: begin
					if (csRise && seenFall_reg) begin
						if (cmdOk && opcode_reg == `OP_ARM) begin
							armLatch_reg <= 1'b1;
						end else if (cmdOk && opcode_reg == `OP_DISARM) begin
							armLatch_reg <= 1'b0;
						end else if (progOk || statOk) begin
							wState_reg    <= W_WAIT;
							wKindPage_reg <= progOk;
							base_reg      <= progBase;
							waitCnt_reg   <= {`WAIT_CNT_W{1'b0}};
						end
					end
				end
				W_WAIT: begin
					// Self-timed cycle length
					waitCnt_reg <= waitCnt_reg + 1'b1;
					if (waitCnt_reg == WAIT_LAST) begin
						copyCnt_reg <= 5'h00;
						if (wKindPage_reg) begin
							wState_reg <= W_COPY;
						end else begin
							lockSel_reg  <= pendLock_reg;
							armLatch_reg <= 1'b0;
							wState_reg   <= W_IDLE;
						end
					end
				end
				W_COPY: begin
					// One staged byte per cycle into the array
					copyCnt_reg <= copyCnt_reg + 5'h01;
					if (copyCnt_reg == `PAGE_BYTES) begin
						armLatch_reg <= 1'b0;
						wState_reg   <= W_IDLE;
					end
				end
				default: begin
					wState_reg <= W_IDLE;
				end
			endcase
		end
	end

	// Array prefetch into the read-ahead buffer; a full buffer stalls it
	always @(posedge mclk) begin
		if (srst) begin
			rdAddr_reg    <= {`ARRAY_AW{1'b0}};
			rdPend_reg    <= 1'b0;
			streaming_reg <= 1'b0;
		end else begin
			rdPend_reg <= rdIssue;
			if (~csActive) begin
				streaming_reg <= 1'b0;
			end else if (byteDone && state_reg == S_ADDR &&
				byteCnt_reg[0] && opcode_reg == `OP_READ) begin
				rdAddr_reg    <= {addrHi_reg[1:0], byteNew};
				streaming_reg <= 1'b1;
			end else if (rdIssue) begin
				rdAddr_reg <= rdAddr_reg + 1'b1;
			end
		end
	end

	// Serial output; array data changed only after falling edges, status bits updated every cycle
	always @(posedge mclk) begin
		if (srst) begin
			so          <= 1'b0;
			soOe        <= 1'b0;
			tx_reg      <= 7'h00;
			txCnt_reg   <= 3'h0;
			statPtr_reg <= 3'h0;
		end else begin
			soOe <= csActive & seenFall_reg;
			if (~csActive) begin
				txCnt_reg   <= 3'h0;
				statPtr_reg <= 3'h0;
			end else if (state_reg == S_STAT) begin
				// Pointer advances on falls even while the write runs
				if (outEdge) begin
					statPtr_reg <= statPtr_reg + 3'h1;
				end
				// Pointer counts falls seen, so it sits one past the bit on show
				if (busy) begin
					so <= 1'b1;
				end else begin
					so <= statusByte[3'h0 - statPtr_reg];
				end
			end else if (outEdge && state_reg == S_READ) begin
				if (txCnt_reg == 3'h0) begin
					so        <= fifoOutData[7];
					tx_reg    <= fifoOutData[6:0];
					txCnt_reg <= 3'h7;
				end else begin
					so        <= tx_reg[6];
					tx_reg    <= {tx_reg[5:0], 1'b0};
					txCnt_reg <= txCnt_reg - 3'h1;
				end
			end
		end
	end

	// Read-ahead buffer, emptied when the frame ends
	read_fifo #(
		.WIDTH (`RFIFO_WIDTH),
		.DEPTH (`RFIFO_DEPTH),
		.PW    (`RFIFO_PTR_W)
	) u_read_fifo (
		.clk      (mclk),
		.srst     (srst),
		.flush    (~streaming_reg),
		.inValid  (rdPend_reg & streaming_reg),
		.inReady  (fifoInReady),
		.inData   (arrayRdData),
		.outValid (fifoOutValid),
		.outReady (fifoPop),
		.outData  (fifoOutData)
	);

	// Main array
	nv_store_ram #(
		.AW (`ARRAY_AW),
		.DW (8)
	) u_array (
		.clk    (mclk),
		.wrEn   (copyWr),
		.wrAddr (copyAddr),
		.wrData (pageRdData),
		.rdEn   (rdIssue),
		.rdAddr (rdAddr_reg),
		.rdData (arrayRdData)
	);

	// Sector staging buffer, held until the exact-count select rise
	nv_store_ram #(
		.AW (`PAGE_AW),
		.DW (8)
	) u_page (
		.clk    (mclk),
		.wrEn   (pageWr),
		.wrAddr (byteCnt_reg[3:0]),
		.wrData (byteNew),
		.rdEn   (wState_reg == W_COPY),
		.rdAddr (copyCnt_reg[3:0]),
		.rdData (pageRdData)
	);
endmodule

// File: dv/spi_flash_protect_checker.sv
// Port-level assertions for the serial memory front end
module spi_flash_protect_checker #(
	parameter int PROG_CYCLES = 1000000
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic csN,
	input wire logic sck,
	input wire logic si,
	input wire logic writeGuardN,
	input wire logic so,
	input wire logic soOe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	logic prevCs_reg;   // Select one cycle ago, low out of reset
	logic seenFall_reg; // A select fall happened since reset
	// Reset value of low means a select already low never counts as a fall
	always_ff @(posedge mclk) begin
		if (srst) begin
			prevCs_reg <= 1'b0;
			seenFall_reg <= 1'b0;
		end else begin
			prevCs_reg <= csN;
			if (prevCs_reg && !csN)
				seenFall_reg <= 1'b1;
		end
	end
	no_early_drive_a: assert property (!seenFall_reg |-> !soOe)
		else $error("output enabled before first select fall");
	deselect_off_a: assert property (csN [*5] |-> !soOe)
		else $error("output driven while deselected");
	end_release_a: assert property ($rose(csN) |-> ##[1:5] !soOe)
		else $error("output not released after select rise");
	sel_drive_a: assert property (seenFall_reg ##0 (!csN) [*5] |-> soOe)
		else $error("output not driven while selected");
	oe_rise_cause_a: assert property ($rose(soOe) |-> !$past(csN, 3) || !$past(csN, 4))
		else $error("output enable rose without select low");
	oe_fall_cause_a: assert property ($fell(soOe) |-> $past(csN, 3) || $past(csN, 4))
		else $error("output enable fell without select high");
	stopped_hi_a: assert property ((soOe && sck) [*8] |=> !$rose(so))
		else $error("output moved while serial clock held high");
	stopped_lo_a: assert property ((soOe && !sck) [*8] |=> !$rose(so))
		else $error("output moved late after serial clock fall");
	// Main scenarios seen
	cover property ($rose(soOe));
	cover property (soOe && $rose(so));
	cover property ($rose(csN) ##1 csN [*4]);
endmodule

// File: dv/spi_host_model.sv
// Host serial master model, mode 0, driving select, clock and data
module spi_host_model (
	input  wire logic mclk,
	input  wire logic so,
	output logic      csN,
	output logic      sck,
	output logic      si
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 8; // Half of an 80 ns serial clock
	// Idle: deselected, clock parked low
	initial begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// Move just after an mclk edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Select fall always precedes any bit
	task automatic sel();
		tick(1);
		csN = 1'b0;
		tick(HALF);
	endtask
	// Deselect; data line toggled so no stale level lingers
	task automatic desel();
		tick(HALF);
		csN = 1'b1;
		si = ~si;
		tick(6);
	endtask
	// One byte MSB first; data set while clock low, reply taken at rise
	task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si = tx[i];
			tick(HALF);
			sck = 1'b1;
			rx[i] = so;
			tick(HALF);
			sck = 1'b0;
		end
	endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the serial memory front end
`include "spi_flash_protect_consts.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PROG = 400; // Shortened write, still outlasts a status frame
	logic       mclk;
	logic       srst;
	logic       writeGuardN;
	wire        csN;
	wire        sck;
	wire        si;
	wire        so;
	wire        soOe;
	wire        soPin = soOe ? so : 1'bz; // Pin level seen by host
	int         fails;
	int         num_checks;
	logic [7:0] r;                        // Last byte received
	spi_flash_protect_protocol #(.PROG_CYCLES(PROG)) DUT (
		.mclk(mclk), .srst(srst), .csN(csN), .sck(sck), .si(si),
		.writeGuardN(writeGuardN), .so(so), .soOe(soOe));
	spi_host_model host (.mclk(mclk), .so(soPin), .csN(csN), .sck(sck), .si(si));
	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic xb(input logic [7:0] tx);
		host.xb(tx, r);
	endtask
	// One-byte frame such as arm or disarm
	task automatic cmd(input logic [7:0] op);
		host.sel();
		xb(op);
		host.desel();
	endtask
	// Fixed wait covering the self-timed write plus copy
	task automatic wait_wr();
		repeat (PROG + 100) @(posedge mclk);
		#1;
	endtask
	task automatic status(input logic [7:0] exp);
		host.sel();
		xb(`OP_STATUS_READ);
		xb(8'h00);
		check(r, exp);
		host.desel();
	endtask
	// Mode 1 drops guard mid-frame, 2 prefixes arm, 3 sends 15 bytes
	task automatic prog(input logic [9:0] a, input logic [7:0] seed, input int mode);
		host.sel();
		if (mode == 2)
			xb(`OP_ARM);
		xb(`OP_PROGRAM);
		xb({6'h00, a[9:8]});
		xb(a[7:0]);
		for (int i = 0; i < ((mode == 3) ? 15 : 16); i++) begin
			if (mode == 1 && i == 8)
				writeGuardN = 1'b0;
			if (mode == 1 && i == 10)
				writeGuardN = 1'b1;
			xb(seed + 8'(i));
		end
		host.desel();
		writeGuardN = 1'b1;
	endtask
	// Leading bytes up to skip are unknown cells and not compared
	task automatic rd(input logic [9:0] a, input logic [7:0] seed, input int n, input int skip);
		host.sel();
		xb(`OP_READ);
		xb({6'h00, a[9:8]});
		xb(a[7:0]);
		for (int i = 0; i < n; i++) begin
			xb(8'h00);
			if (i >= skip)
				check(r, seed + 8'(i - skip));
		end
		host.desel();
	endtask
	task automatic setlock(input logic [2:0] k);
		cmd(`OP_ARM);
		host.sel();
		xb(`OP_STATUS_PROG);
		xb({5'h00, k});
		host.desel();
		wait_wr();
	endtask
	task automatic s_basic();
		check({7'h00, soOe}, 8'h00);
		status(8'h00);
		cmd(`OP_ARM);
		prog(10'h010, 8'h20, 0);
		writeGuardN = 1'b0;
		status(8'hff);
		writeGuardN = 1'b1;
		wait_wr();
		status(8'h00);
		rd(10'h010, 8'h20, 16, 0);
	endtask
	// Every refused program leaves the earlier sector data
	task automatic s_refuse();
		prog(10'h010, 8'h60, 0);
		cmd(`OP_ARM);
		cmd(`OP_DISARM);
		prog(10'h010, 8'h70, 0);
		cmd(`OP_ARM);
		writeGuardN = 1'b0;
		prog(10'h010, 8'h80, 0);
		cmd(`OP_ARM);
		prog(10'h010, 8'h90, 1);
		prog(10'h010, 8'ha0, 2);
		cmd(`OP_ARM);
		prog(10'h010, 8'hc0, 3);
		wait_wr();
		rd(10'h010, 8'h20, 16, 0);
	endtask
	task automatic s_locks();
		for (int k = 7; k >= 0; k--) begin
			setlock(3'(k));
			status({5'h00, 3'(k)});
			if (k == 1) begin
				cmd(`OP_ARM);
				prog(10'h010, 8'hb0, 0);
				wait_wr();
				rd(10'h010, 8'h20, 16, 0);
			end
		end
	endtask
	task automatic s_wrap();
		cmd(`OP_ARM);
		prog(10'h000, 8'h40, 0);
		wait_wr();
		rd(10'h3ff, 8'h40, 3, 1);
	endtask
	initial begin
		fails = 0;
		num_checks = 0;
		srst = 1'b1;
		writeGuardN = 1'b1;
		repeat (5) @(posedge mclk);
		#1;
		srst = 1'b0;
		s_basic();
		s_refuse();
		s_locks();
		s_wrap();
		give_verdict();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge mclk);
		fails++;
		give_verdict();
	end
endmodule
bind spi_flash_protect_protocol spi_flash_protect_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (
	.mclk(mclk), .srst(srst), .csN(csN), .sck(sck), .si(si),
	.writeGuardN(writeGuardN), .so(so), .soOe(soOe));
